// File: rtl/nvm_word_store.v
`timescale 1ns/1ns
`include "trim_loader_defines.vh"

// one nonvolatile word; contents are not touched by reset, only by a program cycle
module nvm_word_store #(
	parameter                        WIDTH      = `CFG_WORD_WIDTH,
	parameter [`NVM_TIMER_WIDTH-1:0] PROG_TICKS = `NVM_PROG_CYCLES,
	parameter [`CFG_WORD_WIDTH-1:0]  INIT_WORD  = `NVM_INIT_WORD
) (
	input  wire             clk_sys_in,
	input  wire             sys_rst_in,
	input  wire             prog_start_in,
	input  wire [WIDTH-1:0] prog_word_in,
	output reg  [WIDTH-1:0] stored_word_out,
	output reg              prog_busy_out
);

	reg [`NVM_TIMER_WIDTH-1:0] timer_q; // cycles left in the program cycle
	reg [WIDTH-1:0]            latch_q; // word being burned
	// the stored cell: starts at the factory content and is never reset,
	// since neither power loss nor chip reset may touch it
	reg [WIDTH-1:0]            cell_q = INIT_WORD[WIDTH-1:0];

	// the output simply shows the cell
	always @* begin
		stored_word_out = cell_q;
	end

	//////////////////////////////////////////////////////////////////////
	// program cycle: word lands in the store only when the timer expires,
	// so a reload during programming still sees the old content
	always @(posedge clk_sys_in) begin
		if (sys_rst_in) begin
			prog_busy_out <= 1'b0;
			timer_q       <= {`NVM_TIMER_WIDTH{1'b0}};
			latch_q       <= {WIDTH{1'b0}};
		end else if (prog_busy_out) begin
			if (timer_q == {{(`NVM_TIMER_WIDTH-1){1'b0}}, 1'b1}) begin
				prog_busy_out   <= 1'b0;
				cell_q          <= latch_q;
			end
			timer_q <= timer_q - {{(`NVM_TIMER_WIDTH-1){1'b0}}, 1'b1};
		end else if (prog_start_in) begin
			prog_busy_out <= 1'b1;
			timer_q       <= PROG_TICKS;
			latch_q       <= prog_word_in;
		end
	end

endmodule // nvm_word_store

// File: rtl/trim_config_shift_loader.v
`timescale 1ns/1ns
`include "trim_loader_defines.vh"

module trim_config_shift_loader #(
	parameter                        WIDTH      = `CFG_WORD_WIDTH,
	parameter [`NVM_TIMER_WIDTH-1:0] PROG_TICKS = `NVM_PROG_CYCLES
) (
	input  wire                     clk_sys_in,
	input  wire                     sys_rst_in,
	input  wire                     serial_clock_in,
	input  wire                     serial_config_in,
	input  wire                     write_strobe_line_in,
	input  wire                     program_mode_select_in,
	input  wire                     chip_reset_line_n_in,
	output reg  [WIDTH-1:0]         trim_word_out,
	output reg  [`FB_CAP_WIDTH-1:0] feedback_cap_select_out,
	output reg                      readback_data_out,
	output reg                      nvm_busy_out,
	output reg                      frame_full_out
);

	// pin bit positions inside the synchroniser vectors
	localparam PIN_SCLK = 0;
	localparam PIN_DATA = 1;
	localparam PIN_WRT  = 2;
	localparam PIN_MODE = 3;
	localparam PIN_RSTN = 4;
	localparam NPINS    = 5;

	// load sequencer states, one-hot
	localparam [2:0] ST_RELOAD = 3'b001; // copy store into volatile word
	localparam [2:0] ST_IDLE   = 3'b010; // shifting and waiting for a strobe
	localparam [2:0] ST_HOLD   = 3'b100; // chip reset held low

	//////////////////////////////////////////////////////////////////////
	// registers and internal nets
	reg  [NPINS-1:0]          meta_q;      // first synchroniser stage
	reg  [NPINS-1:0]          sync_q;      // second stage, safe to use
	reg  [NPINS-1:0]          sync_dly_q;  // one more stage for edge detect
	reg  [WIDTH-1:0]          shift_q;     // incoming word, assembled lsb first
	reg  [`CFG_CNT_WIDTH-1:0] bit_cnt_q;   // bits taken in this frame
	reg  [2:0]                state_q;     // sequencer state
	reg  [2:0]                state_d;     // next sequencer state
	reg                       prog_start_q; // one-cycle request to the store
	wire [WIDTH-1:0]          stored_word; // current nonvolatile content
	wire                      prog_busy;   // store is mid-program
	wire                      sclk_rise;   // serial clock rising edge
	wire                      wrt_rise;    // write strobe rising edge
	wire                      frame_full;  // all bits of a word are in
	wire                      chip_rst_act; // chip reset asserted, synced

	// picks one bit of the volatile word for read-back
	// an index past the last bit reads zero, so read-back after a full frame is quiet
	function readback_bit;
		input [WIDTH-1:0]          word;
		input [`CFG_CNT_WIDTH-1:0] idx;
		begin
			if (idx < `CFG_FULL_COUNT)
				readback_bit = word[idx];
			else
				readback_bit = 1'b0;
		end
	endfunction

	//////////////////////////////////////////////////////////////////////
	// pins come from the host's domain; two flops before any use
	always @(posedge clk_sys_in) begin
		if (sys_rst_in) begin
			// idle levels, so no false edge follows a reset
			meta_q     <= `PIN_IDLE_LEVELS; // reset pin idles high
			sync_q     <= `PIN_IDLE_LEVELS;
			sync_dly_q <= `PIN_IDLE_LEVELS;
		end else begin
			meta_q     <= {chip_reset_line_n_in, program_mode_select_in, write_strobe_line_in,
			               serial_config_in, serial_clock_in};
			sync_q     <= meta_q;
			sync_dly_q <= sync_q;
		end
	end

	//////////////////////////////////////////////////////////////////////
	// edges and levels of the synchronised pins; the third stage feeds the two edges and the strobe falling edge
	assign sclk_rise    = sync_q[PIN_SCLK] & ~sync_dly_q[PIN_SCLK];
	assign wrt_rise     = sync_q[PIN_WRT] & ~sync_dly_q[PIN_WRT];
	assign chip_rst_act = ~sync_q[PIN_RSTN];
	assign frame_full   = (bit_cnt_q == `CFG_FULL_COUNT);

	//////////////////////////////////////////////////////////////////////
	// serial input: each bit enters at the top and moves down, so the
	// first bit sent ends at bit 0 once the whole word is in
	always @(posedge clk_sys_in) begin
		if (sys_rst_in || chip_rst_act) begin
			// power loss or chip reset throws away a partial frame
			shift_q   <= {WIDTH{1'b0}};
			bit_cnt_q <= {`CFG_CNT_WIDTH{1'b0}};
		end else if (sync_dly_q[PIN_WRT] & ~sync_q[PIN_WRT]) begin
			// strobe falling ends the frame; next frame starts at bit 0
			bit_cnt_q <= {`CFG_CNT_WIDTH{1'b0}};
		end else if (sclk_rise && !sync_q[PIN_WRT]) begin
			// clocks while the strobe is high are ignored
			shift_q <= {sync_q[PIN_DATA], shift_q[WIDTH-1:1]};
			// extra clocks past a full word still shift data in; only the count saturates
			if (!frame_full)
				bit_cnt_q <= bit_cnt_q + {{(`CFG_CNT_WIDTH-1){1'b0}}, 1'b1};
		end
	end

	//////////////////////////////////////////////////////////////////////
	// sequencer next state
	always @* begin
		state_d = state_q;
		case (state_q)
			ST_RELOAD: begin
				// a single cycle to copy the store across
				if (chip_rst_act)
					state_d = ST_HOLD;
				else
					state_d = ST_IDLE;
			end
			ST_IDLE: begin
				// shifting goes on here; only a chip reset leaves
				if (chip_rst_act)
					state_d = ST_HOLD;
			end
			ST_HOLD: begin
				// reload happens on release so the word reflects the store then
				if (!chip_rst_act)
					state_d = ST_RELOAD;
			end
			default: begin
				// a lost code recovers through a reload from the store
				state_d = ST_RELOAD;
			end
		endcase
	end

	//////////////////////////////////////////////////////////////////////
	// sequencer state and volatile trim word
	always @(posedge clk_sys_in) begin
		if (sys_rst_in) begin
			// power-up: constant first, store copy a cycle later
			state_q       <= ST_RELOAD;
			trim_word_out <= `TRIM_RESET_VALUE;
			prog_start_q  <= 1'b0;
		end else begin
			state_q      <= state_d;
			prog_start_q <= 1'b0;
			case (state_q)
				ST_RELOAD: begin
					// the stored word becomes the active word
					trim_word_out <= stored_word;
				end
				ST_IDLE: begin
					// a strobe before the word is complete is ignored
					if (wrt_rise && frame_full && !chip_rst_act) begin
						if (sync_q[PIN_MODE]) begin
							// mode select held high: burn the store, active word kept
							if (!prog_busy)
								prog_start_q <= 1'b1;
						end else begin
							trim_word_out <= shift_q;
						end
					end
				end
				ST_HOLD: begin
					// direct-write values are lost while reset is held
					trim_word_out <= `TRIM_RESET_VALUE;
				end
				default: begin
					trim_word_out <= trim_word_out;
				end
			endcase
		end
	end

	//////////////////////////////////////////////////////////////////////
	// field view and status, registered so every output is a flop
	always @(posedge clk_sys_in) begin
		if (sys_rst_in) begin
			feedback_cap_select_out <= {`FB_CAP_WIDTH{1'b0}};
			readback_data_out       <= 1'b0;
			nvm_busy_out            <= 1'b0;
			frame_full_out          <= 1'b0;
		end else begin
			// follows the volatile word one cycle later
			feedback_cap_select_out <= trim_word_out[`FB_CAP_LSB +: `FB_CAP_WIDTH];
			// read-back walks the volatile word bit 0 first, never the store
			readback_data_out       <= readback_bit(trim_word_out, bit_cnt_q);
			// the request cycle counts too, so busy shows no gap before the store starts
			nvm_busy_out            <= prog_busy | prog_start_q;
			// one cycle late, like every status flop
			frame_full_out          <= frame_full;
		end
	end

	//////////////////////////////////////////////////////////////////////
	// nonvolatile store
	// the store takes the frame one cycle after the request; the strobe is
	// still high then, so the shift register cannot move under it
	nvm_word_store #(
		.WIDTH      (WIDTH),
		.PROG_TICKS (PROG_TICKS)
	) u_store (
		.clk_sys_in      (clk_sys_in),
		.sys_rst_in      (sys_rst_in),
		.prog_start_in   (prog_start_q),
		.prog_word_in    (shift_q),
		.stored_word_out (stored_word),
		.prog_busy_out   (prog_busy)
	);

endmodule // trim_config_shift_loader

// File: rtl/trim_loader_defines.vh
`ifndef TRIM_LOADER_DEFINES_VH
`define TRIM_LOADER_DEFINES_VH

// width of the serial configuration word
`define CFG_WORD_WIDTH      60
// width of the bit counter, enough to hold the full count
`define CFG_CNT_WIDTH       6
// full count of bits in one frame
`define CFG_FULL_COUNT      6'h3c
// feedback capacitor select field position and width
`define FB_CAP_LSB          30
`define FB_CAP_WIDTH        10
// volatile word after a synchronous reset, before the reload
`define TRIM_RESET_VALUE    60'h000000000000000
// system clock rate in MHz
`define CLK_RATE_MHZ        100
// nonvolatile store programming time in microseconds
`define NVM_PROG_TIME_US    10
// programming time as a count of clock cycles, 10 us at 100 MHz, sized to the timer
`define NVM_PROG_CYCLES     12'h3e8
// width of the programming timer
`define NVM_TIMER_WIDTH     12
// pin levels the synchroniser holds in reset: chip reset high, all else low
`define PIN_IDLE_LEVELS     5'h10
// content of the nonvolatile word before it is ever programmed
`define NVM_INIT_WORD       60'h000000000000000

`endif

// File: verification/host_adapter_model.sv
`timescale 1ns/1ns
// host adapter: each level held at least 4 clocks, one more than the loader needs
module host_adapter_model #(parameter RST_HOLD = 8) (
	input      clk_sys_in,
	output reg serial_clock_out,
	output reg serial_data_out,
	output reg write_strobe_out,
	output reg mode_select_out,
	output reg chip_reset_n_out
);
	////////////////////////////////////////
	// idle levels; serial clock stands still outside frames
	initial begin
		serial_clock_out = 1'h0;
		serial_data_out = 1'h0;
		write_strobe_out = 1'h0;
		mode_select_out = 1'h0;
		chip_reset_n_out = 1'h1;
	end
	task hold(input integer n);
		repeat (4 * n) @(posedge clk_sys_in);
	endtask
	// n bits, bit 0 first; data then toggles since nothing pulls it
	task send(input [59:0] w, input integer n);
		integer i;
		for (i = 0; i < n; i = i + 1) begin
			serial_data_out <= w[i];
			hold(1);
			serial_clock_out <= 1'h1;
			hold(1);
			serial_clock_out <= 1'h0;
		end
		hold(1);
		serial_data_out <= ~serial_data_out;
	endtask
	// mode leads the strobe and stays up through programming
	task strobe(input m);
		mode_select_out <= m;
		hold(m ? 2 : 1);
		write_strobe_out <= 1'h1;
		hold(m ? 8 : 2);
		write_strobe_out <= 1'h0;
		hold(1);
		mode_select_out <= 1'h0;
		hold(1);
	endtask
	// low for a set time, then room for the reload
	task chip_reset;
		chip_reset_n_out <= 1'h0;
		hold(RST_HOLD);
		chip_reset_n_out <= 1'h1;
		hold(3);
	endtask
endmodule // host_adapter_model

// File: verification/test_trim_config_shift_loader.sv
`timescale 1ns/1ns
module test_trim_config_shift_loader;
	localparam W1 = 60'h5a3c_96f0_e1d2_b48;
	localparam W2 = 60'hc3a5_0f69_2d1e_84b;
	localparam W3 = 60'h1234_5678_9abc_def;
	reg         clk_sys_in = 1'h0;
	reg         sys_rst_in = 1'h1;
	reg         busy_seen = 1'h0;
	wire        sclk, sdat, wstb, mode, crst_n, rb, busy, full;
	wire [59:0] trim;
	wire [9:0]  fb;
	integer     failures = 0;
	integer     checks_done = 0;
	always #5 clk_sys_in = ~clk_sys_in;
	always @(posedge clk_sys_in) if (busy) busy_seen <= 1'h1;
	host_adapter_model host (.clk_sys_in(clk_sys_in), .serial_clock_out(sclk), .serial_data_out(sdat),
		.write_strobe_out(wstb), .mode_select_out(mode), .chip_reset_n_out(crst_n));
	trim_config_shift_loader #(.PROG_TICKS(12'h004)) DUT (.clk_sys_in(clk_sys_in), .sys_rst_in(sys_rst_in),
		.serial_clock_in(sclk), .serial_config_in(sdat), .write_strobe_line_in(wstb),
		.program_mode_select_in(mode), .chip_reset_line_n_in(crst_n), .trim_word_out(trim),
		.feedback_cap_select_out(fb), .readback_data_out(rb), .nvm_busy_out(busy), .frame_full_out(full));
	////////////////////////////////////////
	task chk(input [59:0] got, input [59:0] exp);
		checks_done = checks_done + 1;
		if (got !== exp) begin
			failures = failures + 1;
			$display("BAD %0t got %h want %h", $time, got, exp);
		end
	endtask
	task results;
		if (failures == 0 && checks_done > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	// direct load lands at once, bit 0 first
	task t_direct(input [59:0] w);
		host.send(w, 60);
		chk({59'h0, full}, 60'h1);
		chk({59'h0, rb}, 60'h0);
		host.strobe(0);
		chk(trim, w);
		chk({50'h0, fb}, {50'h0, w[39:30]});
	endtask
	// one bit short: refused, word stays
	task t_short(input [59:0] keep);
		host.send(~keep, 59);
		chk({59'h0, full}, 60'h0);
		chk({59'h0, rb}, {59'h0, keep[59]});
		host.strobe(0);
		chk(trim, keep);
	endtask
	// read-back indexed by the bit count
	task t_read(input [59:0] w);
		integer k;
		for (k = 0; k < 60; k = k + 13) begin
			host.send(w, k);
			chk({59'h0, rb}, {59'h0, w[k]});
			host.strobe(0);
		end
	endtask
	// store write leaves the live word; chip reset reloads
	task t_prog(input [59:0] live, input [59:0] w);
		host.send(w, 60);
		host.strobe(1);
		chk(trim, live);
		chk({59'h0, busy_seen}, 60'h1);
		host.chip_reset;
		chk(trim, w);
	endtask
	// direct load lost at chip reset and power loss
	task t_lose(input [59:0] stored, input [59:0] w);
		t_direct(w);
		host.chip_reset;
		chk(trim, stored);
		t_direct(w);
		sys_rst_in <= 1'h1;
		repeat (10) @(posedge clk_sys_in);
		sys_rst_in <= 1'h0;
		repeat (10) @(posedge clk_sys_in);
		chk(trim, stored);
	endtask
	initial begin
		repeat (10) @(posedge clk_sys_in);
		sys_rst_in <= 1'h0;
		repeat (10) @(posedge clk_sys_in);
		chk(trim, 60'h0);
		t_direct(W1);
		t_short(W1);
		t_read(W1);
		t_prog(W1, W3);
		t_lose(W3, W2);
		results;
	end
	// run needs about 3800 cycles; ample margin
	initial begin
		repeat (40000) @(posedge clk_sys_in);
		failures = failures + 1;
		results;
	end
endmodule // test_trim_config_shift_loader
bind trim_config_shift_loader trim_loader_monitor #(.WIDTH(WIDTH), .PROG_TICKS(PROG_TICKS)) mon (
	.clk_sys_in(clk_sys_in), .sys_rst_in(sys_rst_in), .serial_clock_in(serial_clock_in),
	.serial_config_in(serial_config_in), .write_strobe_line_in(write_strobe_line_in),
	.program_mode_select_in(program_mode_select_in), .chip_reset_line_n_in(chip_reset_line_n_in),
	.trim_word_out(trim_word_out), .feedback_cap_select_out(feedback_cap_select_out),
	.readback_data_out(readback_data_out), .nvm_busy_out(nvm_busy_out), .frame_full_out(frame_full_out));

// File: verification/trim_loader_monitor.sv
`timescale 1ns/1ns
// pin watcher: rebuilds the frame from the pins to judge commits
module trim_loader_monitor #(parameter WIDTH = 60, PROG_TICKS = 4) (
	input             clk_sys_in,
	input             sys_rst_in,
	input             serial_clock_in,
	input             serial_config_in,
	input             write_strobe_line_in,
	input             program_mode_select_in,
	input             chip_reset_line_n_in,
	input [WIDTH-1:0] trim_word_out,
	input [9:0]       feedback_cap_select_out,
	input             readback_data_out,
	input             nvm_busy_out,
	input             frame_full_out
);
	wire             stir = sys_rst_in | ~chip_reset_line_n_in | write_strobe_line_in; // word may move
	wire [9:0]       fb_now = trim_word_out[39:30];
	reg  [3:0]       quiet_q; // cycles since stir, stops at 8
	reg  [6:0]       bits_q;  // serial rises this frame
	reg  [12:0]      busy_q;  // length of the busy run
	reg              sclk_q;
	reg  [WIDTH-1:0] word_q;  // word rebuilt bit 0 first
	////////////////////////////////////////
	// helper state; kept apart from the design's own counters on purpose
	always @(posedge clk_sys_in) begin
		sclk_q <= serial_clock_in;
		busy_q <= nvm_busy_out ? busy_q + 13'h1 : 13'h0;
		quiet_q <= stir ? 4'h0 : quiet_q + {3'h0, quiet_q != 4'h8};
		if (stir)
			bits_q <= 7'h0;
		else if (serial_clock_in & ~sclk_q) begin
			word_q <= {serial_config_in, word_q[WIDTH-1:1]};
			bits_q <= bits_q + {6'h0, bits_q != 7'h3c};
		end
	end
	default clocking @(posedge clk_sys_in); endclocking
	default disable iff (sys_rst_in);
	AST_FIELD: assert property (feedback_cap_select_out == $past(fb_now))
		else $error("field off");
	AST_STILL: assert property (quiet_q == 4'h8 |-> $stable(trim_word_out))
		else $error("word moved unasked");
	AST_DIRECT: assert property ($rose(write_strobe_line_in) && bits_q == 7'h3c
		&& !program_mode_select_in && chip_reset_line_n_in |-> ##[1:6] trim_word_out == word_q)
		else $error("direct load wrong");
	AST_CRST: assert property (!chip_reset_line_n_in [*5] |-> trim_word_out == '0)
		else $error("word kept in reset");
	AST_BUSY: assert property ($fell(nvm_busy_out) |-> busy_q == PROG_TICKS || busy_q == PROG_TICKS + 1)
		else $error("busy length");
	AST_BUSYC: assert property ($rose(nvm_busy_out) |-> program_mode_select_in && quiet_q != 4'h8)
		else $error("busy uncaused");
	AST_FULL: assert property ($rose(frame_full_out) |-> bits_q == 7'h3c)
		else $error("full early");
	AST_EMPTY: assert property (quiet_q == 4'h8 && bits_q != 7'h3c |-> !frame_full_out)
		else $error("full wrong");
	cover property ($rose(nvm_busy_out));
	cover property ($rose(frame_full_out));
	cover property ($rose(chip_reset_line_n_in));
	cover property ($rose(write_strobe_line_in) && bits_q == 7'h3c && !program_mode_select_in);
endmodule // trim_loader_monitor
